//--- src/crfie_pkg.sv
// Constants, register map and state types for the CAN receive-full and interrupt-enable slice.
// Assumes a 32-bit AXI4-Lite bus clocked by aclk with a synchronous active-low reset.
//
// Summary of operation
// - Enable bit 7 gates invalid-message interrupt request.
// - Enable bit 6 gates bus wake-up interrupt.
// - Enable bit 5 gates error interrupt request.
// - Enable bit 4 reads zero, ignores writes.
// - Enable bit 3 gates FIFO-almost-full interrupt.
// - Enable bit 2 gates receive overflow interrupt.
// - Enable bit 1 gates receive buffer interrupt.
// - Enable bit 0 gates transmit buffer interrupt.
// - Module sets buffer-full flag; empty reads zero.
// - Writing zero clears a flag; one does nothing.
// - Low full register holds buffers 0 to 15.
// - High full register holds buffers 16 to 31.
package crfie_pkg;

   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned STRB_W = 4;
   localparam int unsigned NUM_BUF = 32;
   localparam int unsigned HALF_BUF = 16;
   localparam int unsigned NUM_SRC = 8;

   // Word offsets (byte addresses)
   localparam logic [ADDR_W-1:0] OFF_INT_EN = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_RX_BUFFER_FULL_FLAG_LO = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_RX_BUFFER_FULL_FLAG_HI = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_PEND = 8'h0c;

   // Interrupt source bit positions, shared by enable and pending registers
   localparam int unsigned BIT_INVALID_MSG = 7;
   localparam int unsigned BIT_WAKE = 6;
   localparam int unsigned BIT_ERROR = 5;
   localparam int unsigned BIT_UNUSED = 4;
   localparam int unsigned BIT_FIFO_FULL = 3;
   localparam int unsigned BIT_RX_OVF = 2;
   localparam int unsigned BIT_RX_BUF = 1;
   localparam int unsigned BIT_TX_BUF = 0;

   localparam logic [NUM_SRC-1:0] INT_EN_MASK = 8'hef;
   localparam logic [NUM_SRC-1:0] INT_EN_RST = 8'h00;
   localparam logic [NUM_SRC-1:0] PEND_RST = 8'h00;
   localparam logic [NUM_BUF-1:0] RX_BUFFER_FULL_FLAG_RST = 32'h0000_0000;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      CRFIE_W_IDLE = 2'b01,
      CRFIE_W_RESP = 2'b10
   } crfie_wstate_t;

   typedef enum logic [1:0] {
      CRFIE_R_IDLE = 2'b01,
      CRFIE_R_RESP = 2'b10
   } crfie_rstate_t;

endpackage

//--- src/crfie_flag_if.sv
// Carrier between the register front end and a bank of hardware-set flags.
// Assumes set and clr are one-cycle bit masks in the aclk domain.
`timescale 1ns/1ps
interface crfie_flag_if #(parameter int unsigned W = 32) ();
   logic [W-1:0] set;
   logic [W-1:0] clr;
   logic [W-1:0] flags;

   modport ctl (output set, output clr, input flags);
   modport flg (input set, input clr, output flags);
endinterface

//--- src/crfie_rx_buffer_full_flag.sv
// Receive-buffer-full flag bank, one sticky bit per message buffer.
// Assumes set pulses come from the buffer store logic, clears from software writes.
`timescale 1ns/1ps
module crfie_rx_buffer_full_flag
   import crfie_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Flag carrier
   crfie_flag_if.flg fl
);

   logic [NUM_BUF-1:0] full_q;
   logic [NUM_BUF-1:0] full_d;

   genvar i;
   generate
      for (i = 0; i < NUM_BUF; i++) begin : g_buf
         // A store in the same cycle as a clear keeps the flag set
         always_comb begin
            full_d[i] = (full_q[i] & ~fl.clr[i]) | fl.set[i];
         end
      end
   endgenerate

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         full_q <= RX_BUFFER_FULL_FLAG_RST;
      end else begin
         full_q <= full_d;
      end
   end

   assign fl.flags = full_q;

endmodule

//--- src/crfie_irq.sv
// Pending flags for the interrupt sources and their gating by the enable bits.
// Assumes event strobes are one-cycle pulses; the unused source position is never set.
`timescale 1ns/1ps
module crfie_irq
   import crfie_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Pending carrier
   crfie_flag_if.flg pd,
   // Enables and request
   input wire logic [NUM_SRC-1:0] int_en,
   output logic irq
);

   logic [NUM_SRC-1:0] pend_q;
   logic [NUM_SRC-1:0] pend_d;
   logic [NUM_SRC-1:0] gated;

   genvar i;
   generate
      for (i = 0; i < NUM_SRC; i++) begin : g_src
         always_comb begin
            pend_d[i] = ((pend_q[i] & ~pd.clr[i]) | pd.set[i]) & INT_EN_MASK[i];
            gated[i] = pend_q[i] & int_en[i];
         end
      end
   endgenerate

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend_q <= PEND_RST;
      end else begin
         pend_q <= pend_d;
      end
   end

   assign irq = |gated;
   assign pd.flags = pend_q;

endmodule

//--- src/crfie_top.sv
// CAN receive-full flags and interrupt enable registers behind an AXI4-Lite slave.
// Assumes one aclk domain; message-stored and event strobes are synchronous pulses.
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module crfie_top
   import crfie_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [DATA_W-1:0] s_axi_wdata,
   input wire logic [STRB_W-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Protocol engine side
   input wire logic [NUM_BUF-1:0] msg_stored,
   input wire logic [NUM_SRC-1:0] src_event,
   // Interrupt request
   output logic can_irq
);

   crfie_flag_if #(.W(NUM_BUF)) rx_if ();
   crfie_flag_if #(.W(NUM_SRC)) pd_if ();

   // Write channel state
   crfie_wstate_t wstate_q;
   crfie_wstate_t wstate_d;
   logic aw_have_q;
   logic aw_have_d;
   logic w_have_q;
   logic w_have_d;
   logic [ADDR_W-1:0] awaddr_q;
   logic [ADDR_W-1:0] awaddr_d;
   logic [DATA_W-1:0] wdata_q;
   logic [DATA_W-1:0] wdata_d;
   logic [STRB_W-1:0] wstrb_q;
   logic [STRB_W-1:0] wstrb_d;
   logic [1:0] bresp_q;
   logic [1:0] bresp_d;

   // Read channel state
   crfie_rstate_t rstate_q;
   crfie_rstate_t rstate_d;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;
   logic [1:0] rresp_q;
   logic [1:0] rresp_d;

   // Register state
   logic [NUM_SRC-1:0] int_en_q;
   logic [NUM_SRC-1:0] int_en_d;

   logic aw_fire;
   logic w_fire;
   logic do_wr;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic [STRB_W-1:0] wr_strb;
   logic [DATA_W-1:0] lane_mask;
   logic [DATA_W-1:0] zero_bits;
   logic wr_mapped;
   logic rd_mapped;
   logic [DATA_W-1:0] rd_word;

   assign s_axi_awready = (wstate_q == CRFIE_W_IDLE) && !aw_have_q;
   assign s_axi_wready = (wstate_q == CRFIE_W_IDLE) && !w_have_q;
   assign s_axi_bvalid = (wstate_q == CRFIE_W_RESP);
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = (rstate_q == CRFIE_R_IDLE);
   assign s_axi_rvalid = (rstate_q == CRFIE_R_RESP);
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   assign aw_fire = s_axi_awvalid && s_axi_awready;
   assign w_fire = s_axi_wvalid && s_axi_wready;

   // Address and data may arrive in either order; the write commits in the cycle the second of the two is accepted
   assign do_wr = (aw_have_q || aw_fire) && (w_have_q || w_fire);
   assign wr_addr = aw_have_q ? awaddr_q : s_axi_awaddr;
   assign wr_data = w_have_q ? wdata_q : s_axi_wdata;
   assign wr_strb = w_have_q ? wstrb_q : s_axi_wstrb;

   genvar ln;
   generate
      for (ln = 0; ln < STRB_W; ln++) begin : g_lane
         assign lane_mask[8*ln +: 8] = {8{wr_strb[ln]}};
      end
   endgenerate

   // Only enabled byte lanes carrying a zero clear a flag
   assign zero_bits = ~wr_data & lane_mask;

   always_comb begin
      wr_mapped = (wr_addr[ADDR_W-1:2] == OFF_INT_EN[ADDR_W-1:2])
         || (wr_addr[ADDR_W-1:2] == OFF_RX_BUFFER_FULL_FLAG_LO[ADDR_W-1:2])
         || (wr_addr[ADDR_W-1:2] == OFF_RX_BUFFER_FULL_FLAG_HI[ADDR_W-1:2])
         || (wr_addr[ADDR_W-1:2] == OFF_PEND[ADDR_W-1:2]);
   end

   always_comb begin
      wstate_d = wstate_q;
      aw_have_d = aw_have_q;
      w_have_d = w_have_q;
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bresp_d = bresp_q;
      case (wstate_q)
         CRFIE_W_IDLE: begin
            if (aw_fire) begin
               aw_have_d = 1'b1;
               awaddr_d = s_axi_awaddr;
            end
            if (w_fire) begin
               w_have_d = 1'b1;
               wdata_d = s_axi_wdata;
               wstrb_d = s_axi_wstrb;
            end
            if (do_wr) begin
               aw_have_d = 1'b0;
               w_have_d = 1'b0;
               bresp_d = wr_mapped ? RESP_OKAY : RESP_SLVERR;
               wstate_d = CRFIE_W_RESP;
            end
         end
         CRFIE_W_RESP: begin
            if (s_axi_bready) begin
               wstate_d = CRFIE_W_IDLE;
            end
         end
         default: begin
            wstate_d = CRFIE_W_IDLE;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wstate_q <= CRFIE_W_IDLE;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         bresp_q <= RESP_OKAY;
      end else begin
         wstate_q <= wstate_d;
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         bresp_q <= bresp_d;
      end
   end

   // Enable register: the unimplemented position never stores a one
   always_comb begin
      int_en_d = int_en_q;
      if (do_wr && (wr_addr[ADDR_W-1:2] == OFF_INT_EN[ADDR_W-1:2]) && wr_strb[0]) begin
         int_en_d = wr_data[NUM_SRC-1:0] & INT_EN_MASK;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int_en_q <= INT_EN_RST;
      end else begin
         int_en_q <= int_en_d;
      end
   end

   // Flag clear masks, one cycle wide, taken in the commit cycle
   always_comb begin
      rx_if.clr = '0;
      pd_if.clr = '0;
      if (do_wr) begin
         if (wr_addr[ADDR_W-1:2] == OFF_RX_BUFFER_FULL_FLAG_LO[ADDR_W-1:2]) begin
            rx_if.clr[HALF_BUF-1:0] = zero_bits[HALF_BUF-1:0];
         end
         if (wr_addr[ADDR_W-1:2] == OFF_RX_BUFFER_FULL_FLAG_HI[ADDR_W-1:2]) begin
            rx_if.clr[NUM_BUF-1:HALF_BUF] = zero_bits[HALF_BUF-1:0];
         end
         if (wr_addr[ADDR_W-1:2] == OFF_PEND[ADDR_W-1:2]) begin
            pd_if.clr = zero_bits[NUM_SRC-1:0];
         end
      end
   end

   assign rx_if.set = msg_stored;
   assign pd_if.set = src_event;

   crfie_rx_buffer_full_flag u_rx_buffer_full_flag (
      .aclk(aclk),
      .aresetn(aresetn),
      .fl(rx_if)
   );

   crfie_irq u_irq (
      .aclk(aclk),
      .aresetn(aresetn),
      .pd(pd_if),
      .int_en(int_en_q),
      .irq(can_irq)
   );

   // Read decode; unused upper bits read as zero
   always_comb begin
      rd_word = '0;
      rd_mapped = 1'b1;
      case (s_axi_araddr[ADDR_W-1:2])
         OFF_INT_EN[ADDR_W-1:2]: begin
            rd_word[NUM_SRC-1:0] = int_en_q & INT_EN_MASK;
         end
         OFF_RX_BUFFER_FULL_FLAG_LO[ADDR_W-1:2]: begin
            rd_word[HALF_BUF-1:0] = rx_if.flags[HALF_BUF-1:0];
         end
         OFF_RX_BUFFER_FULL_FLAG_HI[ADDR_W-1:2]: begin
            rd_word[HALF_BUF-1:0] = rx_if.flags[NUM_BUF-1:HALF_BUF];
         end
         OFF_PEND[ADDR_W-1:2]: begin
            rd_word[NUM_SRC-1:0] = pd_if.flags;
         end
         default: begin
            rd_mapped = 1'b0;
         end
      endcase
   end

   always_comb begin
      rstate_d = rstate_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      case (rstate_q)
         CRFIE_R_IDLE: begin
            if (s_axi_arvalid) begin
               rdata_d = rd_word;
               rresp_d = rd_mapped ? RESP_OKAY : RESP_SLVERR;
               rstate_d = CRFIE_R_RESP;
            end
         end
         CRFIE_R_RESP: begin
            if (s_axi_rready) begin
               rstate_d = CRFIE_R_IDLE;
            end
         end
         default: begin
            rstate_d = CRFIE_R_IDLE;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rstate_q <= CRFIE_R_IDLE;
         rdata_q <= '0;
         rresp_q <= RESP_OKAY;
      end else begin
         rstate_q <= rstate_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

endmodule

//--- bench/crfie_chk.sv
// Bus and request checker for the CAN receive-full and enable slice.
// Assumes one aclk domain with a synchronous active-low reset.
`timescale 1ns/1ps
module crfie_chk
   import crfie_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [DATA_W-1:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Request
   input wire logic can_irq
);
   logic [ADDR_W-1:0] wa_q, wa_d, ra_q, ra_d;

   // Addresses kept so responses can be judged against what was asked
   always_comb begin
      wa_d = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : wa_q;
      ra_d = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : ra_q;
   end
   always_ff @(posedge aclk) begin
      wa_q <= wa_d;
      ra_q <= ra_d;
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |=> s_axi_bvalid) else $error("write response late");
   chk_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
      $stable(s_axi_bresp)) else $error("write response dropped");
   chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
      $stable(s_axi_rdata)) else $error("read data dropped");
   chk_en_unused: assert property (s_axi_rvalid && ra_q[7:2] == 6'h0 |->
      s_axi_rdata[31:8] == 24'h0 && !s_axi_rdata[4]) else $error("enable bit 4 not zero");
   chk_full_upper: assert property (s_axi_rvalid && ra_q[7:2] inside {6'h1, 6'h2} |->
      s_axi_rdata[31:16] == 16'h0) else $error("full register upper bits set");
   chk_wr_unmapped: assert property (s_axi_bvalid && wa_q[7:2] > 6'h3 |->
      s_axi_bresp == RESP_SLVERR) else $error("unmapped write not refused");
   chk_irq_idle: assert property ($rose(aresetn) |-> !can_irq)
      else $error("request high after reset");

   cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
   cover property (s_axi_rvalid && s_axi_rdata[15:0] != 16'h0);
   cover property ($rose(can_irq));
endmodule

bind crfie_top crfie_chk crfie_chk_inst (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .can_irq(can_irq));

//--- bench/test_can_rx_full_and_int_enable.sv
// Self-checking bench for the CAN receive-full and interrupt-enable slice.
// Assumes crfie_top and its bound checker; one 100 MHz clock.
`timescale 1ns/1ps
module test_can_rx_full_and_int_enable
   import crfie_pkg::*;
;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [ADDR_W-1:0] s_axi_awaddr = 8'h0;
   logic [ADDR_W-1:0] s_axi_araddr = 8'h0;
   logic [DATA_W-1:0] s_axi_wdata = 32'h0;
   logic [STRB_W-1:0] s_axi_wstrb = 4'h0;
   logic [STRB_W-1:0] strb = 4'hf;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [NUM_BUF-1:0] msg_stored = 32'h0;
   logic [NUM_SRC-1:0] src_event = 8'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, can_irq;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [DATA_W-1:0] s_axi_rdata;
   int failures = 0, cmp_count = 0, cyc = 0;

   crfie_top crfie_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .msg_stored(msg_stored), .src_event(src_event),
      .can_irq(can_irq));

   initial begin
      forever #5 aclk = ~aclk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Ready and valid are sampled at the falling edge, where they have settled
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw, w;
      logic b = 1'h0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= strb;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (!b) begin
         @(negedge aclk);
         aw = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         b = s_axi_bvalid;
         if (b) chk({30'h0, s_axi_bresp}, {30'h0, er});
         @(posedge aclk);
         if (aw) s_axi_awvalid <= 1'h0;
         if (w) s_axi_wvalid <= 1'h0;
         if (b) s_axi_bready <= 1'h0;
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic ar;
      logic r = 1'h0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      while (!r) begin
         @(negedge aclk);
         ar = s_axi_arvalid && s_axi_arready;
         r = s_axi_rvalid;
         if (r) chk(s_axi_rdata, ed);
         if (r) chk({30'h0, s_axi_rresp}, {30'h0, er});
         @(posedge aclk);
         if (ar) s_axi_arvalid <= 1'h0;
         if (r) s_axi_rready <= 1'h0;
      end
   endtask

   task automatic t_enables();
      rd(OFF_RX_BUFFER_FULL_FLAG_LO, 32'h0, RESP_OKAY);
      rd(OFF_RX_BUFFER_FULL_FLAG_HI, 32'h0, RESP_OKAY);
      wr(OFF_INT_EN, 32'hffff_ffff, RESP_OKAY);
      rd(OFF_INT_EN, 32'h0000_00ef, RESP_OKAY);
      wr(OFF_INT_EN, 32'h0000_0010, RESP_OKAY);
      rd(OFF_INT_EN, 32'h0, RESP_OKAY);
   endtask

   // Bit 4 has no source, so its enable must never let a request through
   task automatic t_irq_gate();
      for (int i = 0; i < 8; i++) begin
         wr(OFF_INT_EN, 32'h0, RESP_OKAY);
         @(posedge aclk);
         src_event <= 8'h1 << i;
         @(posedge aclk);
         src_event <= 8'h0;
         @(negedge aclk);
         chk({31'h0, can_irq}, 32'h0);
         wr(OFF_INT_EN, 32'h1 << i, RESP_OKAY);
         chk({31'h0, can_irq}, {31'h0, i != 4});
         wr(OFF_PEND, 32'hff, RESP_OKAY);
         chk({31'h0, can_irq}, {31'h0, i != 4});
         wr(OFF_PEND, 32'h0, RESP_OKAY);
         chk({31'h0, can_irq}, 32'h0);
      end
   endtask

   task automatic t_rx_buffer_full_flag();
      @(posedge aclk);
      msg_stored <= 32'h8001_0001;
      @(posedge aclk);
      msg_stored <= 32'h0;
      rd(OFF_RX_BUFFER_FULL_FLAG_LO, 32'h1, RESP_OKAY);
      rd(OFF_RX_BUFFER_FULL_FLAG_HI, 32'h8001, RESP_OKAY);
      // Lane 0 disabled, so the zero written over buffer 0 must not clear it
      strb = 4'he;
      wr(OFF_RX_BUFFER_FULL_FLAG_LO, 32'h0, RESP_OKAY);
      strb = 4'hf;
      rd(OFF_RX_BUFFER_FULL_FLAG_LO, 32'h1, RESP_OKAY);
      wr(OFF_RX_BUFFER_FULL_FLAG_LO, 32'hffff, RESP_OKAY);
      rd(OFF_RX_BUFFER_FULL_FLAG_LO, 32'h1, RESP_OKAY);
      wr(OFF_RX_BUFFER_FULL_FLAG_HI, 32'h7fff, RESP_OKAY);
      rd(OFF_RX_BUFFER_FULL_FLAG_HI, 32'h1, RESP_OKAY);
      for (int n = 0; n < 32; n++) begin
         wr(n < 16 ? OFF_RX_BUFFER_FULL_FLAG_HI : OFF_RX_BUFFER_FULL_FLAG_LO, 32'h0, RESP_OKAY);
         @(posedge aclk);
         msg_stored <= 32'h1 << n;
         @(posedge aclk);
         msg_stored <= 32'h0;
         rd(n < 16 ? OFF_RX_BUFFER_FULL_FLAG_LO : OFF_RX_BUFFER_FULL_FLAG_HI, 32'h1 << (n % 16), RESP_OKAY);
         wr(n < 16 ? OFF_RX_BUFFER_FULL_FLAG_LO : OFF_RX_BUFFER_FULL_FLAG_HI, 32'h0, RESP_OKAY);
         rd(n < 16 ? OFF_RX_BUFFER_FULL_FLAG_LO : OFF_RX_BUFFER_FULL_FLAG_HI, 32'h0, RESP_OKAY);
      end
   endtask

   task automatic t_unmapped();
      wr(8'h10, 32'hffff_ffff, RESP_SLVERR);
      rd(8'h10, 32'h0, RESP_SLVERR);
      // The gating scenario leaves bit 7 enabled; the refused write must not touch it
      rd(OFF_INT_EN, 32'h0000_0080, RESP_OKAY);
   endtask

   // A mid-run reset must drop a live request, the enables and the low receive-full flags
   task automatic t_reset();
      wr(OFF_INT_EN, 32'h1, RESP_OKAY);
      @(posedge aclk);
      src_event <= 8'h1;
      msg_stored <= 32'h0000_0020;
      @(posedge aclk);
      src_event <= 8'h0;
      msg_stored <= 32'h0;
      @(negedge aclk);
      chk({31'h0, can_irq}, 32'h1);
      @(posedge aclk);
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      @(negedge aclk);
      chk({31'h0, can_irq}, 32'h0);
      rd(OFF_INT_EN, 32'h0, RESP_OKAY);
      rd(OFF_RX_BUFFER_FULL_FLAG_LO, 32'h0, RESP_OKAY);
   endtask

   // A hung handshake ends the run here
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         failures++;
         end_of_test();
      end
   end

   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      t_enables();
      t_irq_gate();
      t_rx_buffer_full_flag();
      t_unmapped();
      t_reset();
      end_of_test();
   end
endmodule
